// File: hw/srdp_pkg.sv
package srdp_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam int SRDP_ADDR_W = 9;
  localparam logic [8:0] SRDP_OFS_PERIOD_HIGH = 9'h13a;
  localparam logic [8:0] SRDP_OFS_PERIOD_LOW = 9'h13b;
  localparam logic [8:0] SRDP_OFS_DELAY_HIGH = 9'h13c;
  localparam logic [8:0] SRDP_OFS_DELAY_LOW = 9'h13d;
  localparam logic [8:0] SRDP_OFS_BURST = 9'h13e;
  localparam logic [8:0] SRDP_OFS_FEEDBACK = 9'h13f;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] SRDP_RST_PERIOD_HIGH = 8'h0c;
  localparam logic [7:0] SRDP_RST_PERIOD_LOW = 8'h00;
  localparam logic [7:0] SRDP_RST_DELAY_HIGH = 8'h00;
  localparam logic [7:0] SRDP_RST_DELAY_LOW = 8'h08;
  localparam logic [7:0] SRDP_RST_BURST = 8'h03;
  localparam logic [7:0] SRDP_RST_FEEDBACK = 8'h00;

  // ****************************************
  // Field layouts (writable bit masks and positions)
  // ****************************************
  localparam logic [7:0] SRDP_MASK_HIGH = 8'h1f;
  localparam logic [7:0] SRDP_MASK_BURST = 8'h03;
  localparam logic [7:0] SRDP_MASK_FEEDBACK = 8'hbf;
  localparam int SRDP_COUNT_W = 13;
  localparam int SRDP_BURST_W = 4;
  localparam int SRDP_POS_REF_SEL = 7;
  localparam int SRDP_POS_INNER_FB = 5;
  localparam int SRDP_POS_OUTER_FB = 3;
  localparam int SRDP_POS_ZD_SRC = 1;
  localparam int SRDP_POS_ZD_PWR = 0;

  // ****************************************
  // Source select codes
  // ****************************************
  localparam logic [1:0] SRDP_SRC_SYNC = 2'h0;
  localparam logic [1:0] SRDP_SRC_RECLOCK = 2'h1;
  localparam logic [1:0] SRDP_SRC_PULSER = 2'h2;
  localparam logic [1:0] SRDP_SRC_CONT = 2'h3;

  typedef enum logic [1:0] {
    SRDP_PLS_IDLE,
    SRDP_PLS_ARMED,
    SRDP_PLS_BURST
  } srdp_pulse_state_e;

endpackage : srdp_pkg

// File: hw/srdp_counter.sv
`timescale 1ns/1ps
// ****************************************
// Down counter: one-shot or repeating period
// ****************************************
module srdp_counter
  import srdp_pkg::*;
#(
  parameter int W = 13
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic load_in,
  input wire logic stop_in,
  input wire logic repeat_in,
  input wire logic [W-1:0] value_in,
  output logic [W-1:0] count_out,
  output logic busy_out,
  output logic tick_out
);

  logic [W-1:0] cnt_q;
  logic busy_q;
  logic [W-1:0] gap_q;

  assign count_out = cnt_q;
  assign busy_out = busy_q;
  // Terminal count, suppressed while a fresh load or stop takes over
  assign tick_out = ce_in && busy_q && (cnt_q == '0) && !load_in && !stop_in;

  // Count from value-1 down to zero, so a period spans exactly value cycles
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (ce_in) begin
      if (stop_in) begin
        busy_q <= 1'b0;
      end else if (load_in) begin
        cnt_q <= value_in - W'(1);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == '0) begin
          if (repeat_in) begin
            cnt_q <= value_in - W'(1);
          end else begin
            busy_q <= 1'b0;
          end
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end

  // Helper: enabled cycles since the last load or reload
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      gap_q <= '0;
    end else if (ce_in) begin
      if (load_in || tick_out) begin
        gap_q <= '0;
      end else if (busy_q) begin
        gap_q <= gap_q + W'(1);
      end
    end
  end

  // Each interval lasts exactly the programmed value, checked for values of 8 and above
  a_interval_exact: assert property ( // R02 R05
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    tick_out && (value_in >= W'(8)) |-> gap_q == value_in - W'(1))
    else $error("Counter interval differs from programmed value");

endmodule : srdp_counter

// File: hw/srdp_pulser.sv
`timescale 1ns/1ps
// ****************************************
// Burst pulser: gates a run of divider periods
// ****************************************
module srdp_pulser
  import srdp_pkg::*;
#(
  parameter int BW = SRDP_BURST_W
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic launch_in,
  input wire logic stop_in,
  input wire logic tick_in,
  input wire logic [1:0] code_in,
  output logic active_out,
  output logic busy_out
);

  srdp_pulse_state_e state_q;
  logic [BW-1:0] rem_q;

  assign active_out = (state_q == SRDP_PLS_BURST);
  assign busy_out = (state_q != SRDP_PLS_IDLE);

  // Arm on launch, open at the next period boundary, close after rem periods
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      state_q <= SRDP_PLS_IDLE;
      rem_q <= '0;
    end else if (ce_in) begin
      if (stop_in) begin
        state_q <= SRDP_PLS_IDLE;
      end else if (launch_in) begin
        // A relaunch during a burst restarts it cleanly
        state_q <= SRDP_PLS_ARMED;
        rem_q <= BW'(1) << code_in; // R07
      end else begin
        case (state_q)
          SRDP_PLS_ARMED: begin
            if (tick_in) begin
              state_q <= SRDP_PLS_BURST;
            end
          end
          SRDP_PLS_BURST: begin
            if (tick_in) begin
              if (rem_q == BW'(1)) begin
                state_q <= SRDP_PLS_IDLE;
              end
              rem_q <= rem_q - BW'(1);
            end
          end
          default: begin
            state_q <= SRDP_PLS_IDLE;
          end
        endcase
      end
    end
  end

  // Burst length follows the code: 1, 2, 4 or 8
  a_burst_length: assert property ( // R07
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    ce_in && launch_in && !stop_in |=> rem_q == (BW'(1) << $past(code_in)))
    else $error("Burst length does not match code");

  // A single pulse burst closes at the second period boundary
  a_single_close: assert property ( // R07
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    ce_in && active_out && tick_in && (rem_q == BW'(1)) && !launch_in && !stop_in
    |=> !busy_out)
    else $error("Burst did not close after last period");

endmodule : srdp_pulser

// File: hw/srdp_core.sv
`timescale 1ns/1ps
// Operation
// [R01] Period value is high register bits 4:0 over the full low register.
// [R02] Divider divides by exactly the programmed value, 8 through 8191.
// [R03] Software never programs divide values 0 through 7.
// [R04] Delay value is high register bits 4:0 over the full low register.
// [R05] Digital delay equals the programmed value in steps, 8 through 8191.
// [R06] Burst setting has no effect while the source is continuous.
// [R07] Burst code 0,1,2,3 yields 1,2,4,8 pulses.
// [R08] Burst register write launches a burst if pulser selected and powered.
// [R09] Inner loop reference: oscillator input at 0, reference input at 1.
// [R10] Inner loop divider input: prescaler at 0, feedback mux at 1.
// [R11] Outer loop divider input: oscillator, feedback mux, inner prescaler.
// [R12] Zero-delay source: output six, output eight, divider, external.
// [R13] Software sets the zero-delay path power bit for zero-delay use.
// [R14] Source select: sync, reclocked, pulser, continuous for codes 0 to 3.
// [R15] Power-down disables the divider and all SYSREF output.
// [R16] Split values apply atomically once the low byte is written.
// [R17] Reserved bits read zero and writes to them change nothing.
module srdp_core
  import srdp_pkg::*;
#(
  parameter int CW = SRDP_COUNT_W
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [SRDP_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [1:0] sysref_source_select_in,
  input wire logic sysref_power_down_in,
  input wire logic sync_in,
  output logic sysref_out,
  output logic sysref_burst_busy_out,
  output logic [CW-1:0] sysref_period_count_out,
  output logic [CW-1:0] sysref_delay_count_out,
  output logic inner_loop_ref_select_out,
  output logic inner_loop_feedback_select_out,
  output logic [1:0] outer_loop_feedback_select_out,
  output logic [1:0] zero_delay_source_select_out,
  output logic zero_delay_path_power_out
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] period_high_q;
  logic [7:0] period_low_q;
  logic [7:0] delay_high_q;
  logic [7:0] delay_low_q;
  logic [7:0] burst_q;
  logic [7:0] feedback_q;
  logic [CW-1:0] period_q;
  logic [CW-1:0] delay_q;
  logic [7:0] rdata_q;
  logic wr_period_low;
  logic wr_delay_low;
  logic wr_burst;

  assign wr_period_low = ce_in && reg_wr_in && (reg_addr_in == SRDP_OFS_PERIOD_LOW);
  assign wr_delay_low = ce_in && reg_wr_in && (reg_addr_in == SRDP_OFS_DELAY_LOW);
  assign wr_burst = ce_in && reg_wr_in && (reg_addr_in == SRDP_OFS_BURST);

  // Byte writes; reserved bits are masked so they always hold zero
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      period_high_q <= SRDP_RST_PERIOD_HIGH;
      period_low_q <= SRDP_RST_PERIOD_LOW;
      delay_high_q <= SRDP_RST_DELAY_HIGH;
      delay_low_q <= SRDP_RST_DELAY_LOW;
      burst_q <= SRDP_RST_BURST;
      feedback_q <= SRDP_RST_FEEDBACK;
    end else if (ce_in && reg_wr_in) begin
      case (reg_addr_in)
        SRDP_OFS_PERIOD_HIGH: period_high_q <= reg_wdata_in & SRDP_MASK_HIGH; // R17
        SRDP_OFS_PERIOD_LOW: period_low_q <= reg_wdata_in;
        SRDP_OFS_DELAY_HIGH: delay_high_q <= reg_wdata_in & SRDP_MASK_HIGH; // R17
        SRDP_OFS_DELAY_LOW: delay_low_q <= reg_wdata_in;
        SRDP_OFS_BURST: burst_q <= reg_wdata_in & SRDP_MASK_BURST; // R17
        SRDP_OFS_FEEDBACK: feedback_q <= reg_wdata_in & SRDP_MASK_FEEDBACK; // R17
        default: begin
        end
      endcase
    end
  end

  // Applied 13-bit values change only on the low byte write, so the
  // divider never runs on a half-updated high/low mix
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      period_q <= CW'({SRDP_RST_PERIOD_HIGH[4:0], SRDP_RST_PERIOD_LOW});
      delay_q <= CW'({SRDP_RST_DELAY_HIGH[4:0], SRDP_RST_DELAY_LOW});
    end else begin
      if (wr_period_low) begin
        period_q <= CW'({period_high_q[4:0], reg_wdata_in}); // R01 R16
      end
      if (wr_delay_low) begin
        delay_q <= CW'({delay_high_q[4:0], reg_wdata_in}); // R04 R16
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      rdata_q <= 8'h00;
    end else if (ce_in && reg_rd_in) begin
      case (reg_addr_in)
        SRDP_OFS_PERIOD_HIGH: rdata_q <= period_high_q;
        SRDP_OFS_PERIOD_LOW: rdata_q <= period_low_q;
        SRDP_OFS_DELAY_HIGH: rdata_q <= delay_high_q;
        SRDP_OFS_DELAY_LOW: rdata_q <= delay_low_q;
        SRDP_OFS_BURST: rdata_q <= burst_q;
        SRDP_OFS_FEEDBACK: rdata_q <= feedback_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_out = rdata_q;
  assign sysref_period_count_out = period_q;
  assign sysref_delay_count_out = delay_q;

  // ****************************************
  // Loop and feedback multiplexer selects
  // ****************************************
  assign inner_loop_ref_select_out = feedback_q[SRDP_POS_REF_SEL]; // R09
  assign inner_loop_feedback_select_out = feedback_q[SRDP_POS_INNER_FB]; // R10
  assign outer_loop_feedback_select_out = feedback_q[SRDP_POS_OUTER_FB +: 2]; // R11
  assign zero_delay_source_select_out = feedback_q[SRDP_POS_ZD_SRC +: 2]; // R12
  assign zero_delay_path_power_out = feedback_q[SRDP_POS_ZD_PWR];

  // ****************************************
  // Delay then divider sequencing
  // ****************************************
  logic restart_q;
  logic dly_load;
  logic dly_tick;
  logic div_tick;
  logic div_busy;
  logic [CW-1:0] div_count;
  logic div_level;

  // Restart is pending after reset, power-down or a new value; the set wins
  // over the consume so a write in the consuming cycle is not lost
  assign dly_load = ce_in && restart_q && !sysref_power_down_in;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      restart_q <= 1'b1;
    end else if (ce_in) begin
      if (sysref_power_down_in || wr_period_low || wr_delay_low) begin
        restart_q <= 1'b1; // R15
      end else if (dly_load) begin
        restart_q <= 1'b0;
      end
    end
  end

  srdp_counter #(
    .W(CW)
  ) u_delay (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .load_in(dly_load),
    .stop_in(sysref_power_down_in),
    .repeat_in(1'b0),
    .value_in(delay_q), // R05
    .count_out(),
    .busy_out(),
    .tick_out(dly_tick)
  );

  // Divider starts once the delay has elapsed, and stops on restart
  srdp_counter #(
    .W(CW)
  ) u_divider (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .load_in(dly_tick),
    .stop_in(sysref_power_down_in || dly_load),
    .repeat_in(1'b1),
    .value_in(period_q),
    .count_out(div_count),
    .busy_out(div_busy),
    .tick_out(div_tick)
  );

  // High for the first half of each period (rounded up for odd values)
  assign div_level = div_busy && (div_count >= (period_q >> 1)); // R02

  // ****************************************
  // Burst pulser
  // ****************************************
  logic launch;
  logic burst_active;

  // Launch only with pulser source and circuitry powered; never continuous
  assign launch = wr_burst && (sysref_source_select_in == SRDP_SRC_PULSER)
                  && !sysref_power_down_in; // R06 R08

  srdp_pulser u_pulser (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .launch_in(launch),
    .stop_in(sysref_power_down_in),
    .tick_in(div_tick),
    .code_in(reg_wdata_in[1:0]),
    .active_out(burst_active),
    .busy_out(sysref_burst_busy_out)
  );

  // ****************************************
  // Output source selection
  // ****************************************
  logic reclk_q;
  logic sysref_q;
  logic sysref_d;

  // Re-clocked path samples sync on the divider boundary
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      reclk_q <= 1'b0;
    end else if (ce_in && div_tick) begin
      reclk_q <= sync_in;
    end
  end

  always_comb begin
    sysref_d = 1'b0;
    if (!sysref_power_down_in) begin // R15
      case (sysref_source_select_in) // R14
        SRDP_SRC_SYNC: sysref_d = sync_in;
        SRDP_SRC_RECLOCK: sysref_d = reclk_q;
        SRDP_SRC_PULSER: sysref_d = burst_active && div_level;
        SRDP_SRC_CONT: sysref_d = div_level;
        default: sysref_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      sysref_q <= 1'b0;
    end else if (ce_in) begin
      sysref_q <= sysref_d;
    end
  end

  assign sysref_out = sysref_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_low_write;
    wr_period_low;
  endsequence

  a_period_join: assert property ( // R01
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    s_low_write |=> period_q == {$past(period_high_q[4:0]), $past(reg_wdata_in)})
    else $error("Period value not assembled from high and low bytes");

  a_delay_join: assert property ( // R04
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    wr_delay_low |=> delay_q == {$past(delay_high_q[4:0]), $past(reg_wdata_in)})
    else $error("Delay value not assembled from high and low bytes");

  a_high_atomic: assert property ( // R16
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    !wr_period_low && !wr_delay_low |=> $stable(period_q) && $stable(delay_q))
    else $error("Applied value changed without a low byte write");

  a_reserved_zero: assert property ( // R17
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    ce_in && reg_rd_in && (reg_addr_in == SRDP_OFS_BURST) |=> reg_rdata_out[7:2] == 6'h00)
    else $error("Reserved bits read back nonzero");

  a_launch_arms: assert property ( // R08
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    wr_burst && (sysref_source_select_in == SRDP_SRC_PULSER) && !sysref_power_down_in
    |=> sysref_burst_busy_out && !burst_active)
    else $error("Burst register write did not arm the pulser");

  a_cont_ignores: assert property ( // R06
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    !sysref_burst_busy_out && wr_burst && (sysref_source_select_in == SRDP_SRC_CONT)
    |=> !sysref_burst_busy_out)
    else $error("Burst launched in continuous mode");

  a_cont_follows: assert property ( // R14
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    ce_in && !sysref_power_down_in && (sysref_source_select_in == SRDP_SRC_CONT)
    |=> sysref_out == $past(div_level))
    else $error("Continuous output does not follow divider");

  a_power_quiet: assert property ( // R15
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (ce_in && sysref_power_down_in) [*2] |-> !sysref_out && !div_busy)
    else $error("Output or divider active while powered down");

  a_mux_fields: assert property ( // R09 R10 R11 R12
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    ce_in && reg_wr_in && (reg_addr_in == SRDP_OFS_FEEDBACK)
    |=> inner_loop_ref_select_out == $past(reg_wdata_in[7])
        && inner_loop_feedback_select_out == $past(reg_wdata_in[5])
        && outer_loop_feedback_select_out == $past(reg_wdata_in[4:3])
        && zero_delay_source_select_out == $past(reg_wdata_in[2:1]))
    else $error("Multiplexer select does not match written field");

endmodule : srdp_core

// File: bench/srdp_core_tb_top.sv
`timescale 1ns/1ps
module srdp_core_tb_top
  import srdp_pkg::*;
  ;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [8:0] reg_addr = 9'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] src_sel = 2'h3;
  logic pwr_down = 1'b0;
  logic sync = 1'b0;
  logic [7:0] rdata;
  logic sysref;
  logic busy;
  logic [12:0] period_cnt;
  logic [12:0] delay_cnt;
  logic ref_sel;
  logic inner_fb;
  logic [1:0] outer_fb;
  logic [1:0] zd_src;
  logic zd_pwr;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int h;
  int n;
  int lat8;
  logic [7:0] fb_tbl [6] = '{8'hff, 8'h40, 8'ha5, 8'h5a, 8'h0c, 8'h12};

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  srdp_core dut (
    .ref_clk_in(ref_clk), .rst_b_in(rst_b), .ce_in(ce), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(rdata), .sysref_source_select_in(src_sel),
    .sysref_power_down_in(pwr_down), .sync_in(sync), .sysref_out(sysref),
    .sysref_burst_busy_out(busy), .sysref_period_count_out(period_cnt),
    .sysref_delay_count_out(delay_cnt), .inner_loop_ref_select_out(ref_sel),
    .inner_loop_feedback_select_out(inner_fb), .outer_loop_feedback_select_out(outer_fb),
    .zero_delay_source_select_out(zd_src), .zero_delay_path_power_out(zd_pwr)
  );

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data lands one cycle after the strobe edge, sampled mid-cycle
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask : rd

  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_byte(input logic [8:0] a, input logic [7:0] e);
    logic [7:0] g;
    rd(a, g);
    chk_word($sformatf("reg %h", a), {8'h00, e}, {8'h00, g});
  endtask : chk_byte

  // Bounded wait for a rising edge of the output, cycles counted in n
  task automatic wait_rise(output int n);
    logic prev;
    n = 0;
    do begin
      prev = sysref;
      @(negedge ref_clk);
      n++;
    end while (!(prev === 1'b0 && sysref === 1'b1) && n < 3000);
  endtask : wait_rise

  task automatic measure(output int hi, output int per);
    int k;
    wait_rise(k);
    hi = 0;
    while (sysref === 1'b1 && hi < 9000) begin
      @(negedge ref_clk);
      hi++;
    end
    wait_rise(k);
    per = hi + k;
  endtask : measure

  // Counts pulses until the burst ends, then a margin for strays
  task automatic count_pulses(output int p);
    logic prev;
    int k;
    p = 0;
    k = 0;
    while (k < 600 && (busy === 1'b1 || k < 400)) begin
      prev = sysref;
      @(negedge ref_clk);
      if (prev === 1'b0 && sysref === 1'b1) p++;
      k = (busy === 1'b1) ? k + 1 : ((k < 384) ? 384 : k + 1);
    end
  endtask : count_pulses

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Reset values and applied values
    chk_byte(SRDP_OFS_PERIOD_HIGH, 8'h0c);
    chk_byte(SRDP_OFS_PERIOD_LOW, 8'h00);
    chk_byte(SRDP_OFS_DELAY_HIGH, 8'h00);
    chk_byte(SRDP_OFS_DELAY_LOW, 8'h08);
    chk_byte(SRDP_OFS_BURST, 8'h03);
    chk_byte(SRDP_OFS_FEEDBACK, 8'h00);
    chk_byte(9'h140, 8'h00);
    chk_word("period", 16'h0c00, {3'h0, period_cnt});
    chk_word("delay", 16'h0008, {3'h0, delay_cnt});
    $display("Test reset done");
    // Split values: reserved bits dropped, apply only on low byte
    wr(SRDP_OFS_PERIOD_HIGH, 8'hff);
    chk_byte(SRDP_OFS_PERIOD_HIGH, 8'h1f);
    chk_word("period held", 16'h0c00, {3'h0, period_cnt});
    wr(SRDP_OFS_PERIOD_LOW, 8'hff);
    // Applied value settles after the write edge, so look mid-cycle
    @(negedge ref_clk);
    chk_word("period max", 16'h1fff, {3'h0, period_cnt});
    wr(SRDP_OFS_DELAY_HIGH, 8'ha5);
    chk_byte(SRDP_OFS_DELAY_HIGH, 8'h05);
    chk_word("delay held", 16'h0008, {3'h0, delay_cnt});
    wr(SRDP_OFS_DELAY_LOW, 8'h3c);
    @(negedge ref_clk);
    chk_word("delay split", 16'h053c, {3'h0, delay_cnt});
    wr(SRDP_OFS_BURST, 8'hfe);
    chk_byte(SRDP_OFS_BURST, 8'h02);
    $display("Test split done");
    // Feedback selects, every code of each field
    foreach (fb_tbl[i]) begin
      wr(SRDP_OFS_FEEDBACK, fb_tbl[i]);
      chk_byte(SRDP_OFS_FEEDBACK, fb_tbl[i] & SRDP_MASK_FEEDBACK);
      chk_word("selects", {9'h000, fb_tbl[i][7], fb_tbl[i][5:0]},
        {9'h000, ref_sel, inner_fb, outer_fb, zd_src, zd_pwr});
    end
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(SRDP_OFS_FEEDBACK, 8'h80);
    ce <= 1'b1;
    chk_byte(SRDP_OFS_FEEDBACK, 8'h12);
    $display("Test selects done");
    // Continuous output: period and duty at the smallest legal values
    wr(SRDP_OFS_DELAY_HIGH, 8'h00);
    wr(SRDP_OFS_DELAY_LOW, 8'h08);
    for (int p = 8; p <= 9; p++) begin
      wr(SRDP_OFS_PERIOD_HIGH, 8'h00);
      wr(SRDP_OFS_PERIOD_LOW, 8'(p));
      measure(h, n);
      measure(h, n);
      chk_word("period cycles", 16'(p), 16'(n));
      chk_word("high cycles", 16'((p + 1) / 2), 16'(h));
    end
    $display("Test divider done");
    // Digital delay: latency difference equals the delay difference
    // Same two-write order in both runs, so the divider is already stopped
    // when the latency count starts and no stray edge is taken
    wr(SRDP_OFS_DELAY_LOW, 8'h08);
    wr(SRDP_OFS_PERIOD_LOW, 8'h08);
    wait_rise(lat8);
    wr(SRDP_OFS_DELAY_LOW, 8'h14);
    wr(SRDP_OFS_PERIOD_LOW, 8'h08);
    wait_rise(n);
    chk_word("delay steps", 16'd12, 16'(n - lat8));
    $display("Test delay done");
    // Power down silences the output; bursts are refused
    pwr_down <= 1'b1;
    repeat (3) @(posedge ref_clk);
    h = 0;
    repeat (30) begin
      @(negedge ref_clk);
      if (sysref !== 1'b0) h++;
    end
    chk_word("powered down out", 16'h0000, 16'(h));
    src_sel <= 2'h2;
    wr(SRDP_OFS_BURST, 8'h00);
    @(negedge ref_clk);
    chk_word("busy powered down", 16'h0000, {15'h0, busy});
    pwr_down <= 1'b0;
    // Bursts of 1, 2, 4 and 8 pulses with the pulser selected
    for (int c = 0; c < 4; c++) begin
      wr(SRDP_OFS_BURST, 8'(c));
      @(negedge ref_clk);
      chk_word("busy", 16'h0001, {15'h0, busy});
      count_pulses(n);
      chk_word("pulses", 16'(1 << c), 16'(n));
    end
    $display("Test burst done");
    // Burst writes launch nothing in other source modes
    for (int s = 0; s < 4; s++) begin
      if (s != 2) begin
        src_sel <= 2'(s);
        wr(SRDP_OFS_BURST, 8'h03);
        @(negedge ref_clk);
        chk_word("busy other source", 16'h0000, {15'h0, busy});
      end
    end
    // Sync and re-clocked paths carry the sync level to the output
    @(posedge ref_clk);
    sync <= 1'b1;
    src_sel <= 2'h0;
    repeat (2) @(negedge ref_clk);
    chk_word("sync path", 16'h0001, {15'h0, sysref});
    @(posedge ref_clk);
    src_sel <= 2'h1;
    repeat (12) @(negedge ref_clk);
    chk_word("reclocked path", 16'h0001, {15'h0, sysref});
    @(posedge ref_clk);
    sync <= 1'b0;
    src_sel <= 2'h3;
    measure(h, n);
    chk_word("continuous period", 16'd8, 16'(n));
    $display("Test source modes done");
    give_verdict();
  end
endmodule : srdp_core_tb_top
